// ---- bench/tb.sv ----
// Purpose: self-checking bench for the master transmitter
// Assumes: 40 MHz clock, slave model on the far side
// Notes:   lines resolved here with pull-ups
`timescale 1ns/100ps
module tb;
  import twm_pkg::*;
  logic        clock = 1'b0;
  logic        resetn = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  twm_pins_s   bus_pins;
  logic        irq;
  logic        recv_mode;
  logic        nack = 1'b0;
  logic        grab = 1'b0;
  logic        pull;
  logic [7:0]  rx_byte;
  logic [7:0]  q;
  int          fail_count = 0;
  int          checks = 0;
  int          cycles = 0;
  wire logic   scl = !bus_pins.scl_oe;
  wire logic   sda = !(bus_pins.sda_oe || pull || grab);
  twm_master_tx i_dut
  (
    .CLOCK(clock), .RESETN(resetn), .AVS_ADDRESS(avs_address),
    .AVS_READ(avs_read), .AVS_WRITE(avs_write),
    .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(4'h1),
    .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest),
    .SCL_I(scl), .SDA_I(sda), .BUS_PINS(bus_pins), .IRQ(irq),
    .MASTER_RECEIVE_MODE(recv_mode)
  );
  twm_slave_model i_slave
  (
    .scl(scl), .sda(sda), .nack(nack), .pull(pull), .rx_byte(rx_byte)
  );
  always #12.5 clock = !clock;
  // hang guard
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      fail_count++;
      results();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic results();
    if (fail_count == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
    checks++;
    if (g !== e)
    begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask
  // one register access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [7:0] d);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h00_0000, d};
    @(posedge clock);
    while (avs_waitrequest !== 1'b0) @(posedge clock);
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clock);
  endtask
  // control write, then wait for the next flag and read status
  task automatic step(input logic [7:0] ctl, input logic [7:0] st);
    bus(1'b1, 4'h0, ctl);
    while (irq !== 1'b0) @(posedge clock);
    while (irq !== 1'b1) @(posedge clock);
    bus(1'b0, 4'h4, 8'h00);
    check("status", st, q);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset_values();
    bus(1'b0, 4'h0, 8'h00);
    check("control reset", 8'h00, q);
    bus(1'b0, 4'h4, 8'h00);
    check("status reset", 8'hF8, q);
    bus(1'b0, 4'hC, 8'h00);
    check("unmapped read", 8'h00, q);
  endtask
  task automatic t_collision();
    bus(1'b1, 4'h8, 8'h55);
    bus(1'b0, 4'h8, 8'h00);
    check("dropped data", 8'hFF, q);
    bus(1'b0, 4'h0, 8'h00);
    check("collision bit", 8'h08, q);
    bus(1'b1, 4'h0, 8'h0C);
    bus(1'b0, 4'h0, 8'h00);
    check("collision cleared", 8'h04, q);
  endtask
  task automatic t_write_bytes();
    step(8'hA5, 8'h08);
    bus(1'b1, 4'h8, 8'hA0);
    step(8'h85, 8'h18);
    check("address sent", 8'hA0, rx_byte);
    nack <= 1'b1;
    bus(1'b1, 4'h8, 8'h3C);
    step(8'h85, 8'h30);
    check("refused byte", 8'h3C, rx_byte);
    nack <= 1'b0;
    bus(1'b1, 4'h8, 8'hC3);
    step(8'h85, 8'h28);
    check("taken byte", 8'hC3, rx_byte);
  endtask
  // another driver holds sda low during a released data bit
  task automatic t_arb_loss();
    bus(1'b1, 4'h8, 8'hFF);
    grab <= 1'b1;
    step(8'h85, 8'h38);
    grab <= 1'b0;
    @(posedge clock);
    check("lines after loss", 8'h03, {6'h00, scl, sda});
    step(8'hA5, 8'h08);
    bus(1'b1, 4'h8, 8'hA0);
    step(8'h85, 8'h18);
  endtask
  task automatic t_stop_paths();
    step(8'hB5, 8'h08);
    bus(1'b0, 4'h0, 8'h00);
    check("stop bit after restart", 8'h00, q & 8'h10);
    nack <= 1'b1;
    bus(1'b1, 4'h8, 8'hA0);
    step(8'h85, 8'h20);
    nack <= 1'b0;
    bus(1'b1, 4'h0, 8'h95);
    do bus(1'b0, 4'h0, 8'h00); while (q[4] !== 1'b0);
    check("lines released", 8'h03, {6'h00, scl, sda});
    check("no flag after stop", 8'h00, {7'h00, irq});
  endtask
  task automatic t_restart_read();
    step(8'hA5, 8'h08);
    bus(1'b1, 4'h8, 8'hA0);
    step(8'h85, 8'h18);
    step(8'hA5, 8'h10);
    bus(1'b1, 4'h8, 8'hA1);
    step(8'h85, 8'h40);
    check("read address sent", 8'hA1, rx_byte);
    check("receive mode", 8'h01, {7'h00, recv_mode});
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (5) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    t_reset_values();
    t_collision();
    t_write_bytes();
    t_arb_loss();
    t_stop_paths();
    t_restart_read();
    results();
  end
endmodule // tb

// ---- bench/twm_properties.sv ----
// Purpose: port assertions for the master transmitter
// Assumes: one clock domain, synchronous active-low reset
// Notes:   bound to every twm_master_tx instance
`timescale 1ns/100ps
module twm_properties
(
  input wire logic           CLOCK,
  input wire logic           RESETN,
  input wire logic [3:0]     AVS_ADDRESS,
  input wire logic           AVS_READ,
  input wire logic           AVS_WRITE,
  input wire logic [31:0]    AVS_WRITEDATA,
  input wire logic           AVS_WAITREQUEST,
  input wire logic           SCL_I,
  input wire logic           SDA_I,
  input twm_pkg::twm_pins_s  BUS_PINS,
  input wire logic           IRQ,
  input wire logic           MASTER_RECEIVE_MODE
);
  import twm_pkg::*;
  logic       ie_ff;
  logic [1:0] quiet_ff;
  // accepted control write
  wire logic ctl_wr = AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == 4'h0;
  // shadow of the interrupt enable bit
  always_ff @(posedge CLOCK)
  begin
    if (!RESETN) ie_ff <= 1'b0;
    else if (ctl_wr) ie_ff <= AVS_WRITEDATA[0];
  end
  // cycles with the request up and no write in flight
  always_ff @(posedge CLOCK)
  begin
    if (!RESETN || !IRQ || AVS_WRITE) quiet_ff <= 2'h0;
    else if (quiet_ff != 2'h3) quiet_ff <= quiet_ff + 2'h1;
  end
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RESETN);
  sequence s_answer;
    !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
  endsequence
  chk_reset_quiet: assert property ($rose(RESETN) |-> AVS_WAITREQUEST
    && !IRQ && !BUS_PINS.sda_oe && !BUS_PINS.scl_oe)
    else $error("outputs not quiet after reset");
  chk_one_answer: assert property ((AVS_READ || AVS_WRITE)
    && AVS_WAITREQUEST |=> s_answer) else $error("bus answer late");
  chk_open_drain: assert property (!BUS_PINS.scl_o && !BUS_PINS.sda_o)
    else $error("pin driven high");
  chk_start_free: assert property (
    $rose(BUS_PINS.sda_oe) && !BUS_PINS.scl_oe |->
    $past(SCL_I, 2) && $past(SDA_I, 2)) else $error("start on busy bus");
  chk_hold_pins: assert property (quiet_ff == 2'h3 |-> $stable(BUS_PINS))
    else $error("pins moved while flag set");
  chk_clear_flag: assert property (
    ctl_wr && AVS_WRITEDATA[7] |-> ##[1:3] !IRQ)
    else $error("flag clear ignored");
  chk_irq_enable: assert property ($rose(IRQ) |-> ie_ff)
    else $error("request without enable");
  chk_irq_mask: assert property (ctl_wr && !AVS_WRITEDATA[0]
    |=> ##[0:1] !IRQ) else $error("request not masked");
  chk_recv_flag: assert property (
    $rose(MASTER_RECEIVE_MODE) && ie_ff |-> ##[0:3] IRQ)
    else $error("receive mode without flag");
endmodule // twm_properties

bind twm_master_tx twm_properties i_chk
(
  .CLOCK, .RESETN, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA,
  .AVS_WAITREQUEST, .SCL_I, .SDA_I, .BUS_PINS, .IRQ, .MASTER_RECEIVE_MODE
);

// ---- bench/twm_slave_model.sv ----
// Purpose: slave receiver on the two-wire bus
// Assumes: lines resolved with pull-ups by the bench
// Notes:   answers each ninth bit, refuses when told
`timescale 1ns/100ps
module twm_slave_model
(
  input  wire logic  scl,
  input  wire logic  sda,
  input  wire logic  nack,
  output logic       pull,
  output logic [7:0] rx_byte
);
  int         bit_cnt = 0;
  logic [7:0] shift_ff = 8'h00;
  initial pull = 1'b0;
  initial rx_byte = 8'h00;
  // start or repeated start restarts the count
  always @(negedge sda)
  begin
    if (scl) bit_cnt = 0;
  end
  // shift in on each of the first eight rising clocks, count every one
  always @(posedge scl)
  begin
    if (bit_cnt < 8) shift_ff = {shift_ff[6:0], sda};
    bit_cnt = bit_cnt + 1;
    if (bit_cnt == 8) rx_byte = shift_ff;
  end
  // answer bit driven between falling clocks, released after
  always @(negedge scl)
  begin
    pull = (bit_cnt == 8) && !nack;
    if (bit_cnt == 9) bit_cnt = 0;
  end
endmodule // twm_slave_model

// ---- rtl/twm_map.svh ----
// Purpose: register map, field positions, status codes and timing values in ns
// Assumes: Avalon-MM, 32-bit words, byte addresses
// Notes:   included by the transmitter design file only
`ifndef TWM_MAP_SVH
`define TWM_MAP_SVH
`define TWM_OFS_CTRL    4'h0
`define TWM_OFS_STAT    4'h4
`define TWM_OFS_DATA    4'h8
`define TWM_BIT_FLAG    7
`define TWM_BIT_ACKEN   6
`define TWM_BIT_STA     5
`define TWM_BIT_STO     4
`define TWM_BIT_WCOL    3
`define TWM_BIT_EN      2
`define TWM_BIT_IE      0
`define TWM_ST_START    8'h08
`define TWM_ST_RSTART   8'h10
`define TWM_ST_AW_ACK   8'h18
`define TWM_ST_AW_NACK  8'h20
`define TWM_ST_D_ACK    8'h28
`define TWM_ST_D_NACK   8'h30
`define TWM_ST_ARB      8'h38
`define TWM_ST_AR_ACK   8'h40
`define TWM_ST_AR_NACK  8'h48
`define TWM_ST_IDLE     8'hF8
`define TWM_PRE_MASK    8'hF8
`define TWM_HALF_NS     2500
`define TWM_CLK_NS      25
`endif

// ---- rtl/twm_master_tx.sv ----
// Purpose: two-wire master transmitter with Avalon-MM register slave
// Assumes: 40 MHz CLOCK, synchronous active-low RESETN, open-drain pins
// Notes:   receive and slave modes are out of scope; an address with
//          the read bit ends in a hold with the receive mode marked
`timescale 1ns/100ps
`include "twm_map.svh"
module twm_master_tx
(
  input  wire logic              CLOCK,
  input  wire logic              RESETN,
  input  wire logic [3:0]        AVS_ADDRESS,
  input  wire logic              AVS_READ,
  input  wire logic              AVS_WRITE,
  input  wire logic [31:0]       AVS_WRITEDATA,
  input  wire logic [3:0]        AVS_BYTEENABLE,
  output logic      [31:0]       AVS_READDATA,
  output logic                   AVS_WAITREQUEST,
  input  wire logic              SCL_I,
  input  wire logic              SDA_I,
  output twm_pkg::twm_pins_s     BUS_PINS,
  output logic                   IRQ,
  output logic                   MASTER_RECEIVE_MODE
);
  import twm_pkg::*;
  localparam int HALF_CYC = `TWM_HALF_NS / `TWM_CLK_NS;
  ////////////////////////////////////////////////////////////////////////
  // synchronised bus lines
  logic [1:0] bus_in;
  twm_sync #(.W(2)) u_sync
  (
    .clk  (CLOCK),
    .rst_n(RESETN),
    .din  ({SCL_I, SDA_I}),
    .dout (bus_in)
  );
  wire scl_s = bus_in[1];
  wire sda_s = bus_in[0];
  ////////////////////////////////////////////////////////////////////////
  // registers and state
  logic [7:0] ctrl_ff;
  logic [7:0] data_ff;
  logic [7:0] stat_ff;
  logic [7:0] sh_ff;
  logic [2:0] bit_ff;
  logic [1:0] ph_ff;
  logic [7:0] cnt_ff;
  logic       busy_ff;
  logic       sda_pv_ff;
  logic       scl_pv_ff;
  logic       own_ff;
  logic       addr_ff;
  logic       stpst_ff;
  logic       ack_ff;
  logic       ack_done_ff;
  twm_state_e st_ff;
  twm_state_e nxt_st;
  // bus decode, one-cycle answer
  wire acc      = AVS_READ | AVS_WRITE;
  wire wr_ctrl  = AVS_WRITE & ~AVS_WAITREQUEST
                  & (AVS_ADDRESS == `TWM_OFS_CTRL) & AVS_BYTEENABLE[0];
  wire wr_data  = AVS_WRITE & ~AVS_WAITREQUEST
                  & (AVS_ADDRESS == `TWM_OFS_DATA) & AVS_BYTEENABLE[0];
  wire [7:0] wd = AVS_WRITEDATA[7:0];
  wire flag     = ctrl_ff[`TWM_BIT_FLAG];
  wire enable   = ctrl_ff[`TWM_BIT_EN];
  // writing one to the flag clears it; with the enable bit also set it launches the command in that same write
  wire go       = wr_ctrl & wd[`TWM_BIT_FLAG] & wd[`TWM_BIT_EN];
  wire w_sta    = wd[`TWM_BIT_STA];
  wire w_sto    = wd[`TWM_BIT_STO];
  wire [7:0] rdv = (AVS_ADDRESS == `TWM_OFS_CTRL) ? ctrl_ff :
                   (AVS_ADDRESS == `TWM_OFS_STAT) ? stat_ff :
                   (AVS_ADDRESS == `TWM_OFS_DATA) ? data_ff : 8'h00;
  // bus free tracking: START seen makes busy, STOP frees
  wire st_cond  = scl_s & scl_pv_ff & sda_pv_ff & ~sda_s;
  wire sp_cond  = scl_s & scl_pv_ff & ~sda_pv_ff & sda_s;
  wire tick     = (cnt_ff == 8'(HALF_CYC - 1));
  // data/status states in which a command may follow
  wire in_tx    = (stat_ff == `TWM_ST_AW_ACK) | (stat_ff == `TWM_ST_AW_NACK)
                  | (stat_ff == `TWM_ST_D_ACK) | (stat_ff == `TWM_ST_D_NACK);
  wire in_adr   = (stat_ff == `TWM_ST_START) | (stat_ff == `TWM_ST_RSTART);
  // arbitration lost: released SDA high but line reads low at SCL high
  wire arb_lost = (st_ff == ST_BIT) & (ph_ff == 2'd2) & sh_ff[7] & ~sda_s;
  ////////////////////////////////////////////////////////////////////////
  // next state of the bit engine
  always_comb
  begin
    nxt_st = st_ff;
    unique case (st_ff)
      ST_IDLE:
        if (flag)
          nxt_st = ST_IDLE;
      ST_WAITB:
        if (!busy_ff)
          nxt_st = ST_START;
      ST_START, ST_RSTRT, ST_STOP:
        nxt_st = st_ff;
      ST_BIT:
        if (arb_lost)
          nxt_st = ST_HOLD;
      ST_ACK:
        nxt_st = st_ff;
      ST_HOLD:
        nxt_st = st_ff;
    endcase
  end
  ////////////////////////////////////////////////////////////////////////
  // avalon answer: waitrequest drops one cycle after the request
  always_ff @(posedge CLOCK)
  begin
    if (!RESETN)
    begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA    <= 32'h0000_0000;
    end
    else
    begin
      AVS_WAITREQUEST <= ~(acc & AVS_WAITREQUEST);
      AVS_READDATA    <= {24'h00_0000, rdv};
    end
  end
  // line history for condition detection and timer
  always_ff @(posedge CLOCK)
  begin
    if (!RESETN)
    begin
      scl_pv_ff <= 1'b1;
      sda_pv_ff <= 1'b1;
      busy_ff   <= 1'b0;
      cnt_ff    <= 8'h00;
    end
    else
    begin
      scl_pv_ff <= scl_s;
      sda_pv_ff <= sda_s;
      busy_ff   <= st_cond ? 1'b1 : (sp_cond ? 1'b0 : busy_ff);
      cnt_ff    <= (tick || st_ff == ST_IDLE || st_ff == ST_HOLD
                    || st_ff == ST_WAITB) ? 8'h00 : cnt_ff + 8'h01;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // protocol engine with register side effects
  always_ff @(posedge CLOCK)
  begin
    if (!RESETN)
    begin
      ctrl_ff  <= 8'h00;
      data_ff  <= 8'hFF;
      stat_ff  <= `TWM_ST_IDLE;
      st_ff    <= ST_IDLE;
      sh_ff    <= 8'hFF;
      bit_ff   <= 3'd0;
      ph_ff    <= 2'd0;
      own_ff   <= 1'b0;
      addr_ff  <= 1'b0;
      stpst_ff <= 1'b0;
      ack_ff   <= 1'b0;
      ack_done_ff <= 1'b0;
      BUS_PINS <= '{scl_o: 1'b0, scl_oe: 1'b0, sda_o: 1'b0, sda_oe: 1'b0};
      IRQ      <= 1'b0;
      MASTER_RECEIVE_MODE <= 1'b0;
    end
    else
    begin
      IRQ <= flag & ctrl_ff[`TWM_BIT_IE];
      // data writes only land while the flag is high
      if (wr_data)
      begin
        if (flag)
          data_ff <= wd;
        else
          ctrl_ff[`TWM_BIT_WCOL] <= 1'b1;
      end
      if (wr_ctrl)
      begin
        ctrl_ff[`TWM_BIT_ACKEN] <= wd[`TWM_BIT_ACKEN];
        ctrl_ff[`TWM_BIT_STA]   <= w_sta;
        ctrl_ff[`TWM_BIT_STO]   <= w_sto;
        ctrl_ff[`TWM_BIT_EN]    <= wd[`TWM_BIT_EN];
        ctrl_ff[`TWM_BIT_IE]    <= wd[`TWM_BIT_IE];
        if (wd[`TWM_BIT_FLAG])
          ctrl_ff[`TWM_BIT_FLAG] <= 1'b0;
        if (wd[`TWM_BIT_WCOL])
          ctrl_ff[`TWM_BIT_WCOL] <= 1'b0;
      end
      // command dispatch on flag clear; engine idles while flag set
      if (go && (st_ff == ST_IDLE || st_ff == ST_HOLD))
      begin
        ph_ff <= 2'd0;
        if (w_sto && own_ff && (in_tx || stat_ff == `TWM_ST_ARB))
        begin
          stpst_ff <= w_sta;
          st_ff    <= ST_STOP;
        end
        else if (w_sta && own_ff && in_tx)
          st_ff <= ST_RSTRT;
        else if (w_sta)
          st_ff <= ST_WAITB;
        else if (own_ff && (in_adr || in_tx))
        begin
          sh_ff   <= data_ff;
          addr_ff <= in_adr;
          bit_ff  <= 3'd7;
          st_ff   <= ST_BIT;
        end
        else if (stat_ff == `TWM_ST_ARB)
        begin
          own_ff  <= 1'b0;
          BUS_PINS.scl_oe <= 1'b0;
          BUS_PINS.sda_oe <= 1'b0;
          stat_ff <= `TWM_ST_IDLE;
          st_ff   <= ST_IDLE;
        end
      end
      else if (enable)
      begin
        unique case (st_ff)
          ST_WAITB:
            st_ff <= nxt_st;
          // sda falls while scl high, then scl falls
          ST_START, ST_RSTRT:
            if (tick)
            begin
              ph_ff <= ph_ff + 2'd1;
              unique case (ph_ff)
                2'd0:
                begin
                  BUS_PINS.sda_oe <= 1'b0;
                  BUS_PINS.scl_oe <= (st_ff == ST_RSTRT);
                end
                2'd1: BUS_PINS.scl_oe <= 1'b0;
                2'd2: BUS_PINS.sda_oe <= 1'b1;
                2'd3:
                begin
                  BUS_PINS.scl_oe <= 1'b1;
                  own_ff  <= 1'b1;
                  ctrl_ff[`TWM_BIT_FLAG] <= 1'b1;
                  stat_ff <= (st_ff == ST_RSTRT) ? `TWM_ST_RSTART
                                                 : `TWM_ST_START;
                  st_ff   <= ST_IDLE;
                end
              endcase
            end
          // each bit: low phase sets data, first high phase samples
          ST_BIT, ST_ACK:
            if (arb_lost)
            begin
              BUS_PINS.sda_oe <= 1'b0;
              ctrl_ff[`TWM_BIT_FLAG] <= 1'b1;
              stat_ff <= `TWM_ST_ARB;
              own_ff  <= 1'b0;
              st_ff   <= ST_HOLD;
            end
            else if (tick)
            begin
              ph_ff <= ph_ff + 2'd1;
              unique case (ph_ff)
                2'd0: BUS_PINS.sda_oe <= (st_ff == ST_BIT) & ~sh_ff[7];
                2'd1: BUS_PINS.scl_oe <= 1'b0;
                2'd2: ack_ff <= sda_s;
                2'd3:
                begin
                  BUS_PINS.scl_oe <= 1'b1;
                  if (st_ff == ST_BIT && bit_ff != 3'd0)
                  begin
                    bit_ff <= bit_ff - 3'd1;
                    sh_ff  <= {sh_ff[6:0], 1'b1};
                  end
                  else if (st_ff == ST_BIT)
                    st_ff <= ST_ACK;
                  else
                  begin
                    ctrl_ff[`TWM_BIT_FLAG] <= 1'b1;
                    BUS_PINS.sda_oe <= 1'b0;
                    st_ff <= ST_IDLE;
                    if (addr_ff && data_ff[0])
                    begin
                      MASTER_RECEIVE_MODE <= 1'b1;
                      stat_ff <= ack_ff ? `TWM_ST_AR_NACK : `TWM_ST_AR_ACK;
                    end
                    else if (addr_ff)
                      stat_ff <= ack_ff ? `TWM_ST_AW_NACK
                                        : `TWM_ST_AW_ACK;
                    else
                      stat_ff <= ack_ff ? `TWM_ST_D_NACK
                                        : `TWM_ST_D_ACK;
                  end
                end
              endcase
            end
          // sda low, scl released, sda released while scl high
          ST_STOP:
            if (tick)
            begin
              ph_ff <= ph_ff + 2'd1;
              unique case (ph_ff)
                2'd0: BUS_PINS.sda_oe <= 1'b1;
                2'd1: BUS_PINS.scl_oe <= 1'b0;
                2'd2: BUS_PINS.sda_oe <= 1'b0;
                2'd3:
                begin
                  ctrl_ff[`TWM_BIT_STO] <= 1'b0;
                  own_ff  <= 1'b0;
                  MASTER_RECEIVE_MODE <= 1'b0;
                  stat_ff <= `TWM_ST_IDLE;
                  st_ff   <= stpst_ff ? ST_WAITB : ST_IDLE;
                end
              endcase
            end
          default:
            st_ff <= st_ff;
        endcase
      end
      BUS_PINS.scl_o <= 1'b0;
      BUS_PINS.sda_o <= 1'b0;
    end
  end
  // status low three bits always read zero (no prescaler here)
endmodule // twm_master_tx

// ---- rtl/twm_pkg.sv ----
// Purpose: shared types of the two-wire master transmitter
// Assumes: state codes are set here, not in twm_map.svh
// Notes:   struct carries the bus-side view of the pins
package twm_pkg;
  typedef struct packed
  {
    logic scl_o;
    logic scl_oe;
    logic sda_o;
    logic sda_oe;
  } twm_pins_s;
  typedef enum logic [7:0]
  {
    ST_IDLE  = 8'b0000_0001,
    ST_START = 8'b0000_0010,
    ST_BIT   = 8'b0000_0100,
    ST_ACK   = 8'b0000_1000,
    ST_HOLD  = 8'b0001_0000,
    ST_STOP  = 8'b0010_0000,
    ST_RSTRT = 8'b0100_0000,
    ST_WAITB = 8'b1000_0000
  } twm_state_e;
endpackage

// ---- rtl/twm_sync.sv ----
// Purpose: two flip-flop synchroniser for the bus lines
// Assumes: inputs asynchronous to CLOCK
// Notes:   only the second stage is read outside
`timescale 1ns/100ps
module twm_sync
#(
  parameter int W = 2
)
(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_ff;
  // first stage feeds second stage only; idle bus reads high
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta_ff <= {W{1'b1}};
      dout    <= {W{1'b1}};
    end
    else
    begin
      meta_ff <= din;
      dout    <= meta_ff;
    end
  end
endmodule // twm_sync
